// ### include/cirq_pkg.sv
// Package for the CAN interrupt and timer mode control slice
package cirq_pkg;

  // Register byte offsets (the mode register is the only offset that software both reads and writes)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_IRQ_SET = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATE = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TIMER = 8'h18;

  // Mode register fields
  localparam int MODE_TTM = 5;
  localparam int MODE_FREEZE = 6;
  localparam int MODE_REPEAT_DIS = 7;
  localparam int MODE_SYNC_LO = 24;
  localparam int MODE_SYNC_HI = 25;
  localparam logic [31:0] MODE_READ_MASK = 32'h0000_00ff;

  // Status and interrupt bit positions
  localparam int NUM_MBOX = 8;
  localparam int BIT_ERR_ACTIVE = 16;
  localparam int BIT_WARN = 17;
  localparam int BIT_ERR_PASSIVE = 18;
  localparam int BIT_BUS_OFF = 19;
  localparam int BIT_SLEEP = 20;
  localparam int BIT_WAKEUP = 21;
  localparam int BIT_TIMER_OVERFLOW_FLAG = 22;
  localparam int BIT_TIMESTAMP_FLAG = 23;
  localparam int BIT_CRC = 24;
  localparam int BIT_BIT_ERR = 28;
  localparam int BIT_RX_BUSY = 29;
  localparam int BIT_TX_BUSY = 30;
  localparam int BIT_OVL_BUSY = 31;

  // Sources that carry an interrupt mask; read-clear flags
  localparam logic [31:0] IRQ_VALID = 32'h1fff_00ff;
  localparam logic [31:0] READ_CLEAR = 32'h1fc0_0000;

  localparam logic [15:0] TIMER_MAX = 16'hffff;
  localparam logic [15:0] TIMER_ONE = 16'h0001;
  localparam logic [1:0] SYNC_TWO_RISE = 2'h0;
  localparam logic [1:0] SYNC_RISE_FALL = 2'h1;
  localparam logic [1:0] SYNC_ONE_RISE = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } cirq_bus_e;

  // Events from the protocol engine
  typedef struct packed {
    logic [7:0] mbox_event;
    logic err_active;
    logic warn;
    logic err_passive;
    logic bus_off;
    logic sleep;
    logic wakeup;
    logic timestamp;
    logic [4:0] bus_err;
    logic rx_busy;
    logic tx_busy;
    logic ovl_busy;
    logic timer_tick;
    logic timer_reset;
    logic last_mbox_rx;
    logic arb_lost;
    logic [2:0] arb_lost_mbox;
  } cirq_engine_s;

  typedef struct packed {
    cirq_bus_e bus;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] mode;
    logic [31:0] mask;
    logic [31:0] status;
    logic [15:0] timer;
    logic irq;
    logic [7:0] pending;
    logic [7:0] mbox_abort_flag;
    logic [7:0] mbox_ready_flag;
    logic rx_s1;
    logic rx_s2;
    logic rx_out;
  } cirq_state_s;

endpackage : cirq_pkg

// ### rtl/cirq_ctrl.sv
// CAN interrupt, status and timer mode control slice with Wishbone register access
// Summary of operation
// - Timer freeze clear: 16-bit timer wraps from ffff to zero and keeps counting.
// - Timer freeze set: timer stops at ffff until a timer reset.
// - Repeat disable clear: lost arbitration keeps the mailbox request pending.
// - Repeat disable set: lost arbitration aborts request, sets abort and ready flags.
// - Sync depth 0 two rising, 1 rising plus falling, 2 one rising, else none.
// - Sync depth field is writable but reads back as zero.
// - Enable register write sets mask bits written as one.
// - Disable register write clears mask bits written as one.
// - Mask register reads one for each enabled source.
// - Bits 0 to 7 are mailbox n events; bits 8 to 15 unused.
// - Bus errors: crc 24, stuffing 25, ack 26, form 27, bit 28.
// - Error states: active 16, warning 17, passive 18, bus off 19.
// - Sleep 20, wakeup 21, timer overflow 22, timestamp 23.
// - Status alone shows rx busy 29, tx busy 30, overload busy 31.
// - Reading status clears timer overflow, timestamp and bus error flags.
// - Time-triggered mode: last mailbox reception resets timer, releasing a freeze.
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module cirq_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cirq_pkg::cirq_engine_s engine,
  input wire logic [7:0] tx_request,
  input wire logic can_rx,
  output logic [7:0] tx_pending,
  output logic [7:0] mbox_abort_flag,
  output logic [7:0] mbox_ready_flag,
  output logic [15:0] timer_value,
  output logic rx_sync,
  output logic irq
);

  cirq_pkg::cirq_state_s r;
  cirq_pkg::cirq_state_s next_r;
  logic rx_neg;

  // Byte-lane merge of a write
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return m;
  endfunction : lane_mask

  // Falling-edge stage for the rising-plus-falling sync path
  always_ff @(negedge sys_clk) begin
    if (reset) begin
      rx_neg <= 1'b0;
    end else begin
      rx_neg <= r.rx_s1;
    end
  end

  always_comb begin
    logic [31:0] wmask;
    logic [31:0] events;
    logic [1:0] depth;
    logic req;
    logic rd_status;
    wmask = 32'h0000_0000;
    events = 32'h0000_0000;
    depth = 2'h0;
    req = 1'b0;
    rd_status = 1'b0;
    next_r = r;
    req = wb_cyc_i && wb_stb_i;
    wmask = wb_dat_i & lane_mask(wb_sel_i);
    depth = r.mode[cirq_pkg::MODE_SYNC_HI:cirq_pkg::MODE_SYNC_LO];

    // Bus slave: one wait state, ack dropped after one cycle
    next_r.ack = 1'b0;
    case (r.bus)
      cirq_pkg::ST_IDLE: begin
        if (req) begin
          next_r.ack = 1'b1;
          next_r.bus = cirq_pkg::ST_ACK;
          next_r.rdata = 32'h0000_0000;
          if (wb_we_i) begin
            case (wb_adr_i)
              cirq_pkg::OFS_MODE: begin
                next_r.mode = (r.mode & ~lane_mask(wb_sel_i)) | wmask;
              end
              cirq_pkg::OFS_IRQ_SET: begin
                next_r.mask = r.mask | (wmask & cirq_pkg::IRQ_VALID);
              end
              cirq_pkg::OFS_IRQ_CLR: begin
                next_r.mask = r.mask & ~wmask;
              end
              default: begin
              end
            endcase
          end else begin
            case (wb_adr_i)
              cirq_pkg::OFS_MODE: next_r.rdata = r.mode & cirq_pkg::MODE_READ_MASK;
              cirq_pkg::OFS_IRQ_STATE: next_r.rdata = r.mask;
              cirq_pkg::OFS_STATUS: begin
                next_r.rdata = r.status;
                rd_status = 1'b1;
              end
              cirq_pkg::OFS_TIMER: next_r.rdata = {16'h0000, r.timer};
              default: next_r.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      cirq_pkg::ST_ACK: begin
        next_r.bus = cirq_pkg::ST_IDLE;
      end
      default: begin
        next_r.bus = cirq_pkg::ST_IDLE;
      end
    endcase

    // Timer
    if (engine.timer_reset || (r.mode[cirq_pkg::MODE_TTM] && engine.last_mbox_rx)) begin
      next_r.timer = 16'h0000;
    end else if (engine.timer_tick) begin
      if (r.timer == cirq_pkg::TIMER_MAX) begin
        if (r.mode[cirq_pkg::MODE_FREEZE]) begin
          next_r.timer = r.timer;
        end else begin
          next_r.timer = 16'h0000;
        end
        events[cirq_pkg::BIT_TIMER_OVERFLOW_FLAG] = 1'b1;
      end else begin
        next_r.timer = r.timer + cirq_pkg::TIMER_ONE;
      end
    end

    // Mailbox transfer requests and arbitration loss; an abort in the same cycle wins
    next_r.pending = r.pending | tx_request;
    next_r.mbox_abort_flag = r.mbox_abort_flag & ~tx_request;
    next_r.mbox_ready_flag = r.mbox_ready_flag & ~tx_request;
    if (engine.arb_lost) begin
      if (r.mode[cirq_pkg::MODE_REPEAT_DIS]) begin
        next_r.pending[engine.arb_lost_mbox] = 1'b0;
        next_r.mbox_abort_flag[engine.arb_lost_mbox] = 1'b1;
        next_r.mbox_ready_flag[engine.arb_lost_mbox] = 1'b1;
        events[engine.arb_lost_mbox] = 1'b1;
      end else begin
        next_r.pending[engine.arb_lost_mbox] = r.pending[engine.arb_lost_mbox];
      end
    end
    // Status: mailbox events, level flags, sticky read-clear flags
    events[cirq_pkg::NUM_MBOX-1:0] = events[cirq_pkg::NUM_MBOX-1:0] | engine.mbox_event;
    events[cirq_pkg::BIT_TIMESTAMP_FLAG] = engine.timestamp;
    events[cirq_pkg::BIT_BIT_ERR:cirq_pkg::BIT_CRC] = engine.bus_err;
    next_r.status[cirq_pkg::NUM_MBOX-1:0] = (r.mbox_abort_flag | r.mbox_ready_flag)
      | events[cirq_pkg::NUM_MBOX-1:0];
    next_r.status[15:8] = 8'h00;
    next_r.status[cirq_pkg::BIT_ERR_ACTIVE] = engine.err_active;
    next_r.status[cirq_pkg::BIT_WARN] = engine.warn;
    next_r.status[cirq_pkg::BIT_ERR_PASSIVE] = engine.err_passive;
    next_r.status[cirq_pkg::BIT_BUS_OFF] = engine.bus_off;
    next_r.status[cirq_pkg::BIT_SLEEP] = engine.sleep;
    next_r.status[cirq_pkg::BIT_WAKEUP] = engine.wakeup;
    if (rd_status) begin
      next_r.status = next_r.status & ~cirq_pkg::READ_CLEAR;
    end
    // Set wins over the read clear
    next_r.status = next_r.status | (events & cirq_pkg::READ_CLEAR) | (r.status & cirq_pkg::READ_CLEAR
      & ~(rd_status ? cirq_pkg::READ_CLEAR : 32'h0000_0000));
    next_r.status[cirq_pkg::BIT_RX_BUSY] = engine.rx_busy;
    next_r.status[cirq_pkg::BIT_TX_BUSY] = engine.tx_busy;
    next_r.status[cirq_pkg::BIT_OVL_BUSY] = engine.ovl_busy;

    next_r.irq = |(r.status & r.mask & cirq_pkg::IRQ_VALID);

    // Receive input synchroniser
    next_r.rx_s1 = can_rx;
    next_r.rx_s2 = r.rx_s1;
    case (depth)
      cirq_pkg::SYNC_TWO_RISE: next_r.rx_out = r.rx_s2;
      cirq_pkg::SYNC_RISE_FALL: next_r.rx_out = rx_neg;
      cirq_pkg::SYNC_ONE_RISE: next_r.rx_out = r.rx_s1;
      default: next_r.rx_out = can_rx;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '0;
      r.bus <= cirq_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign tx_pending = r.pending;
  assign mbox_abort_flag = r.mbox_abort_flag;
  assign mbox_ready_flag = r.mbox_ready_flag;
  assign timer_value = r.timer;
  assign rx_sync = r.rx_out;
  assign irq = r.irq;

endmodule : cirq_ctrl

// ### tb/cirq_ctrl_sva.sv
// Checker for the interrupt and timer control slice
`timescale 1ns/100ps
module cirq_ctrl_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire cirq_pkg::cirq_engine_s engine,
  input wire logic [7:0] tx_request,
  input wire logic [7:0] tx_pending,
  input wire logic [7:0] mbox_abort_flag,
  input wire logic [7:0] mbox_ready_flag,
  input wire logic [15:0] timer_value,
  input wire logic irq
);
  logic [2:0] lost_q;
  always_ff @(posedge sys_clk) lost_q <= engine.arb_lost_mbox;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o);
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_LATENCY: assert property (s_take |=> s_answer) else $error("ack latency wrong");
  AST_ACK_NOREQ: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=> !irq && tx_pending == 8'h00)
    else $error("outputs not cleared by reset");
  AST_TIMER_STEP: assert property (engine.timer_tick && !engine.timer_reset && !engine.last_mbox_rx
    && timer_value != 16'hffff |=> timer_value == $past(timer_value) + 16'h0001) else $error("timer step");
  AST_TIMER_TOP: assert property (engine.timer_tick && timer_value == 16'hffff
    |=> timer_value inside {16'h0000, 16'hffff}) else $error("timer top");
  AST_TIMER_CLEAR: assert property (engine.timer_reset |=> timer_value == 16'h0000)
    else $error("timer reset");
  AST_REQ_SET: assert property (tx_request != 8'h00 && !engine.arb_lost
    |=> (tx_pending & $past(tx_request)) == $past(tx_request)
    && (mbox_ready_flag & $past(tx_request)) == 8'h00) else $error("request not pending");
  AST_ARB_LOST: assert property (engine.arb_lost && tx_pending[engine.arb_lost_mbox] && tx_request == 8'h00
    |=> tx_pending[lost_q] != (mbox_abort_flag[lost_q] && mbox_ready_flag[lost_q])) else $error("arb lost");
  AST_IRQ_HOLD: assert property (irq && engine == $past(engine) && engine == $past(engine, 2)
    && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) && $past(tx_request, 2) == 8'h00 |=> irq)
    else $error("irq dropped");
endmodule : cirq_ctrl_sva

// ### tb/cirq_node.sv
// Far side node model driving the receive line
`timescale 1ns/100ps
module cirq_node (
  input wire logic sys_clk,
  input wire logic send,
  input wire logic [7:0] pattern,
  output logic can_rx,
  output logic bit_end
);
  logic [5:0] cnt = 6'h00;
  logic busy = 1'b0;
  always_ff @(posedge sys_clk) begin
    if (send && !busy) begin
      busy <= 1'b1;
      cnt <= 6'h00;
    end else if (busy) begin
      cnt <= cnt + 6'h01;
      busy <= (cnt != 6'h3f);
    end
  end
  // Recessive when idle, eight cycles a bit
  assign can_rx = busy ? pattern[3'h7 - cnt[5:3]] : 1'b1;
  assign bit_end = busy && (cnt[2:0] == 3'h7);
endmodule : cirq_node

// ### tb/tb_cirq_ctrl.sv
// Testbench for the interrupt and timer control slice
`timescale 1ns/100ps
module tb_cirq_ctrl;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rq;
  logic ack;
  cirq_pkg::cirq_engine_s eng = '0;
  logic [7:0] tx_req = 8'h00;
  logic send = 1'b0;
  logic can_rx;
  logic bit_end;
  logic [7:0] pend;
  logic [7:0] abrt;
  logic [7:0] rdy;
  logic [15:0] tmr;
  logic rx_sync;
  logic irq;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int lat = 0;
  logic last_bit = 1'b1;
  always #5 sys_clk = ~sys_clk;
  cirq_ctrl cirq_ctrl_inst (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .engine(eng),
    .tx_request(tx_req), .can_rx(can_rx), .tx_pending(pend), .mbox_abort_flag(abrt), .mbox_ready_flag(rdy),
    .timer_value(tmr), .rx_sync(rx_sync), .irq(irq));
  cirq_node cirq_node_inst (.sys_clk(sys_clk), .send(send), .pattern(8'h96), .can_rx(can_rx), .bit_end(bit_end));
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 70000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) fail_count++;
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hf, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(nm, e, rq);
  endtask : rdc
  task automatic tick(input int n);
    eng.timer_tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    eng.timer_tick <= 1'b0;
    @(posedge sys_clk);
  endtask : tick
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdc("mask", 8'h0c, 32'h0);
    wb(1'b1, 8'h04, 4'h4, 32'hffff_ffff);
    rdc("mask", 8'h0c, 32'h00ff_0000);
    wr(8'h04, 32'hffff_ffff);
    rdc("mask", 8'h0c, 32'h1fff_00ff);
    wr(8'h08, 32'h1000_00f0);
    rdc("mask", 8'h0c, 32'h0fff_000f);
    rdc("unmapped", 8'h14, 32'h0);
    $display("Test masks done");
    eng <= 30'h002b_d780;
    @(posedge sys_clk);
    eng.timestamp <= 1'b0;
    eng.bus_err <= 5'h00;
    rdc("status", 8'h10, 32'hf5b5_0000);
    rdc("status", 8'h10, 32'he035_0000);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h08, 32'h003f_0000);
    eng.wakeup <= 1'b0;
    wr(8'h04, 32'h0020_0000);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("Test status done");
    eng <= '0;
    tx_req <= 8'h08;
    for (int r = 0; r < 2; r++) begin
      @(posedge sys_clk);
      tx_req <= 8'h00;
      eng.arb_lost <= 1'b1;
      eng.arb_lost_mbox <= 3'h3;
      @(posedge sys_clk);
      eng.arb_lost <= 1'b0;
      @(posedge sys_clk);
      chk("pending", r ? 32'h0 : 32'h8, {24'h0, pend});
      chk("flags", r ? 32'h0808 : 32'h0, {16'h0, abrt, rdy});
      wr(8'h00, 32'h0300_0080);
    end
    rdc("mode", 8'h00, 32'h0000_0080);
    rdc("status", 8'h10, 32'h0000_0008);
    $display("Test mailbox done");
    for (int m = 0; m < 4; m++) begin
      lat = (m == 0) ? 3 : ((m == 3) ? 1 : 2);
      wr(8'h00, {6'h0, m[1:0], 24'h0});
      send <= 1'b1;
      @(posedge sys_clk);
      send <= 1'b0;
      last_bit = 1'b1;
      for (int i = 0; i < 70; i++) begin
        @(negedge sys_clk);
        if (bit_end) chk("rx_sync", {31'h0, can_rx}, {31'h0, rx_sync});
        if (i < 64 && i % 8 == lat - 1) chk("rx_sync_old", {31'h0, last_bit}, {31'h0, rx_sync});
        if (i < 64 && i % 8 == lat) chk("rx_sync_new", {31'h0, can_rx}, {31'h0, rx_sync});
        if (bit_end) last_bit = can_rx;
      end
      @(posedge sys_clk);
    end
    $display("Test sync done");
    wr(8'h00, 32'h0000_0040);
    tick(65540);
    chk("timer", 32'hffff, {16'h0, tmr});
    rdc("status", 8'h10, 32'h0040_0008);
    rdc("status", 8'h10, 32'h0000_0008);
    wr(8'h00, 32'h0);
    tick(1);
    chk("timer", 32'h0, {16'h0, tmr});
    tick(3);
    rdc("timer", 8'h18, 32'h3);
    eng.timer_reset <= 1'b1;
    @(posedge sys_clk);
    eng.timer_reset <= 1'b0;
    wr(8'h00, 32'h0000_0020);
    tick(3);
    eng.last_mbox_rx <= 1'b1;
    @(posedge sys_clk);
    eng.last_mbox_rx <= 1'b0;
    @(posedge sys_clk);
    chk("timer", 32'h0, {16'h0, tmr});
    $display("Test timer done");
    print_verdict();
  end
endmodule : tb_cirq_ctrl
bind cirq_ctrl cirq_ctrl_sva cirq_ctrl_sva_inst (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .engine(engine), .tx_request(tx_request), .tx_pending(tx_pending),
  .mbox_abort_flag(mbox_abort_flag), .mbox_ready_flag(mbox_ready_flag), .timer_value(timer_value), .irq(irq));
